// file: inc/dmg_regs.svh
// Constants of the discharge measurement gating block
// Notes on behaviour
// - Permit set when conversion accepted: discharge outputs unchanged for whole conversion unless a mute command turns them off.
// - Permit clear: output off while its own or adjacent cell converts.
// - Permit clear: forced-off beats enable bit; else active only if active before command.
// - Mute turns off all discharge outputs, enable bits kept unchanged.
// - Unmute outside a conversion restores the outputs given by the current enable bits, not a saved copy of those active before mute.
// - Permit clear: converting cell k forces off k-1, k, k+1 cyclic in six-group.
`ifndef DMG_REGS_SVH
`define DMG_REGS_SVH
`define DMG_NUM_CELLS 18
`define DMG_GROUP_SIZE 6
`define DMG_NUM_GROUPS 3
`define DMG_ADDR_CTRL 12'h000
`define DMG_ADDR_ENABLE 12'h004
`define DMG_ADDR_CMD 12'h008
`define DMG_ADDR_STATUS 12'h00c
`define DMG_ADDR_OUTPUT 12'h010
`define DMG_ADDR_PERIOD 12'h014
`define DMG_CTRL_PERMIT_BIT 0
`define DMG_CMD_CONV_BIT 0
`define DMG_CMD_CONV_FIRST_BIT 1
`define DMG_CMD_MUTE_BIT 2
`define DMG_CMD_UNMUTE_BIT 3
`define DMG_PERIOD_RESET 16'h0010
`endif

// file: inc/dmg_pkg.sv
// Types of the discharge measurement gating block
package dmg_pkg;
  typedef enum logic [1:0] {
    DMG_IDLE,
    DMG_MEAS,
    DMG_CAL
  } dmg_state_e;
endpackage : dmg_pkg

// file: verilog/dmg_sequencer.sv
// Conversion period sequencer: walks six measurement then six calibration slots, only slot 0 of each with first_only
`timescale 1ns/100ps
`default_nettype none
`include "dmg_regs.svh"
module dmg_sequencer
  import dmg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  input wire logic first_only,
  input wire logic [15:0] period,
  // Status
  output logic busy,
  output logic [2:0] slot,
  output logic done
);
  dmg_state_e state_q, state_d;
  logic [2:0] slot_q, slot_d;
  logic [15:0] cnt_q, cnt_d;
  logic first_q, first_d;
  logic done_q, done_d;

  always_comb begin
    state_d = state_q;
    slot_d = slot_q;
    cnt_d = cnt_q;
    first_d = first_q;
    done_d = 1'b0;
    case (state_q)
      DMG_IDLE: begin
        if (start) begin
          state_d = DMG_MEAS;
          slot_d = 3'h0;
          cnt_d = 16'h0000;
          first_d = first_only;
        end
      end
      DMG_MEAS, DMG_CAL: begin
        if (cnt_q + 16'h0001 >= period) begin
          cnt_d = 16'h0000;
          if (slot_q == 3'h5 || first_q) begin
            slot_d = 3'h0;
            if (state_q == DMG_MEAS) begin
              state_d = DMG_CAL;
            end else begin
              state_d = DMG_IDLE;
              done_d = 1'b1;
            end
          end else begin
            slot_d = slot_q + 3'h1;
          end
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default: begin
        state_d = DMG_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DMG_IDLE;
      slot_q <= 3'h0;
      cnt_q <= 16'h0000;
      first_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      slot_q <= slot_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      done_q <= done_d;
    end
  end

  assign busy = (state_q != DMG_IDLE);
  assign slot = slot_q;
  assign done = done_q;
endmodule : dmg_sequencer
`default_nettype wire

// file: verilog/dmg_gating.sv
// Discharge output gating around cell conversions, with APB registers
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "dmg_regs.svh"
module dmg_gating
  import dmg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Discharge outputs and conversion busy flag
  output logic [`DMG_NUM_CELLS-1:0] discharge_out,
  output logic conv_busy
);
  logic permit_q, permit_d;
  logic [`DMG_NUM_CELLS-1:0] enable_q, enable_d;
  logic muted_q, muted_d;
  logic conv_permit_q, conv_permit_d;
  logic [`DMG_NUM_CELLS-1:0] pre_q, pre_d;
  logic [15:0] period_q, period_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic pready_q, pready_d;
  logic [`DMG_NUM_CELLS-1:0] out_q, out_d;
  logic busy_q;
  logic [`DMG_GROUP_SIZE-1:0] force_off;
  logic wr, rd, start, first_only, seq_busy;
  logic [2:0] slot;

  // Forced-off mask within one six-cell group for converted cell k
  function automatic logic [5:0] adj_mask(input logic [2:0] k);
    logic [5:0] m;
    m = 6'h00;
    case (k)
      3'h0: m = 6'h23;
      3'h1: m = 6'h07;
      3'h2: m = 6'h0e;
      3'h3: m = 6'h1c;
      3'h4: m = 6'h38;
      3'h5: m = 6'h31;
      default: m = 6'h00;
    endcase
    return m;
  endfunction : adj_mask

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction : hit

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign start = wr && hit(paddr, `DMG_ADDR_CMD) && pwdata[`DMG_CMD_CONV_BIT] && !seq_busy;
  assign first_only = pwdata[`DMG_CMD_CONV_FIRST_BIT];

  dmg_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .first_only(first_only),
    .period(period_q),
    .busy(seq_busy),
    .slot(slot),
    .done()
  );

  // Configuration registers
  always_comb begin
    permit_d = permit_q;
    enable_d = enable_q;
    period_d = period_q;
    if (wr && hit(paddr, `DMG_ADDR_CTRL)) begin
      permit_d = pwdata[`DMG_CTRL_PERMIT_BIT];
    end
    if (wr && hit(paddr, `DMG_ADDR_ENABLE)) begin
      enable_d = pwdata[`DMG_NUM_CELLS-1:0];
    end
    if (wr && hit(paddr, `DMG_ADDR_PERIOD)) begin
      period_d = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_q <= 1'b0;
      enable_q <= '0;
      period_q <= `DMG_PERIOD_RESET;
    end else begin
      permit_q <= permit_d;
      enable_q <= enable_d;
      period_q <= period_d;
    end
  end

  // Permit and output state held from the accepted conversion command
  always_comb begin
    conv_permit_d = conv_permit_q;
    pre_d = pre_q;
    if (start) begin
      conv_permit_d = permit_q;
      pre_d = out_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_permit_q <= 1'b0;
      pre_q <= '0;
    end else begin
      conv_permit_q <= conv_permit_d;
      pre_q <= pre_d;
    end
  end

  // Mute state, kept across conversions; mute wins over unmute
  always_comb begin
    muted_d = muted_q;
    if (wr && hit(paddr, `DMG_ADDR_CMD)) begin
      if (pwdata[`DMG_CMD_MUTE_BIT]) begin
        muted_d = 1'b1;
      end else if (pwdata[`DMG_CMD_UNMUTE_BIT]) begin
        muted_d = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      muted_q <= 1'b0;
    end else begin
      muted_q <= muted_d;
    end
  end

  // Output gating per cell; unforced cells come back as they were before the command
  always_comb begin
    force_off = adj_mask(slot);
    out_d = enable_q;
    if (muted_q) begin
      out_d = '0;
    end else if (seq_busy && !conv_permit_q) begin
      for (int g = 0; g < `DMG_NUM_GROUPS; g++) begin
        for (int c = 0; c < `DMG_GROUP_SIZE; c++) begin
          if (force_off[c]) begin
            out_d[g*`DMG_GROUP_SIZE+c] = 1'b0;
          end else begin
            out_d[g*`DMG_GROUP_SIZE+c] = pre_q[g*`DMG_GROUP_SIZE+c] && enable_q[g*`DMG_GROUP_SIZE+c];
          end
        end
      end
    end else if (seq_busy && conv_permit_q) begin
      out_d = out_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      busy_q <= 1'b0;
    end else begin
      out_q <= out_d;
      busy_q <= seq_busy;
    end
  end

  // APB read data and response; unmapped accesses answer zero with an error
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = psel && !penable;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `DMG_ADDR_CTRL: prdata_d[0] = permit_q;
        `DMG_ADDR_ENABLE: prdata_d[`DMG_NUM_CELLS-1:0] = enable_q;
        `DMG_ADDR_CMD: prdata_d = 32'h0000_0000;
        `DMG_ADDR_STATUS: prdata_d[2:0] = {conv_permit_q, muted_q, seq_busy};
        `DMG_ADDR_OUTPUT: prdata_d[`DMG_NUM_CELLS-1:0] = out_q;
        `DMG_ADDR_PERIOD: prdata_d[15:0] = period_q;
        default: pslverr_d = 1'b1;
      endcase
      if (!rd && !pslverr_d) begin
        prdata_d = prdata_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= pready_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign discharge_out = out_q;
  assign conv_busy = busy_q;
endmodule : dmg_gating
`default_nettype wire

// file: test/dmg_checker.sv
// Port assertions of the gating block
`timescale 1ns/100ps
`default_nettype none
module dmg_checker (
  // Clock and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic [17:0] discharge_out,
  input wire logic conv_busy
);
  logic [17:0] pre_q;
  wire logic cmd_w = psel && penable && pready && pwrite && paddr == 12'h008;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 18'h0;
    end else if (!conv_busy) begin
      pre_q <= discharge_out;
    end
  end
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_resp: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  a_reset_out: assert property (!$past(presetn) |-> discharge_out == 18'h0) else $error("reset out");
  a_only_before: assert property (conv_busy |-> (discharge_out & ~pre_q) == 18'h0) else $error("rose");
  a_conv_start: assert property (cmd_w && pwdata[0] && !conv_busy |-> ##[1:3] conv_busy) else $error("start");
  a_mute_clear: assert property (cmd_w && pwdata[2] |-> ##[1:3] discharge_out == 18'h0) else $error("mute");
  c_conv: cover property (cmd_w && pwdata[0]);
  c_mute: cover property (cmd_w && pwdata[2]);
  c_err: cover property (pslverr);
endmodule : dmg_checker
bind dmg_gating dmg_checker u_chk (.*);
`default_nettype wire

// file: test/dmg_host.sv
// APB host model of the gating block
`timescale 1ns/100ps
`default_nettype none
module dmg_host (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic conv_busy
);
  logic [31:0] rdat;
  logic rerr;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : xfer
  task run(input logic [31:0] cmd);
    xfer(1'b1, 12'h008, cmd);
    while (conv_busy !== 1'b1) @(posedge pclk);
    while (conv_busy === 1'b1) @(posedge pclk);
  endtask : run
  task measure(input int tc);
    xfer(1'b1, 12'h008, 32'h4);
    run(32'h3);
    repeat (6 * tc) @(posedge pclk);
    run(32'h1);
    xfer(1'b1, 12'h008, 32'h8);
  endtask : measure
endmodule : dmg_host
`default_nettype wire

// file: test/test_dmg_gating.sv
// Bench of the discharge gating block
`timescale 1ns/100ps
`default_nettype none
module test_dmg_gating;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] discharge_out, last;
  logic [17:0] en = 18'h3fffe;
  logic [17:0] q[$];
  logic [5:0] g;
  int n_mismatch = 0;
  int n_checks = 0;
  dmg_gating dut (.*);
  dmg_host h (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Gated patterns seen during a conversion, pushed on each change from the previous cycle unless equal to en
  always @(posedge pclk) begin
    if (conv_busy === 1'b1 && discharge_out !== last && discharge_out !== en) q.push_back(discharge_out);
    last = discharge_out;
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task rd(input logic [11:0] a, input logic [31:0] exp);
    h.xfer(1'b0, a, 32'h0);
    chk("prdata", h.rdat, exp);
  endtask : rd
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4000) @(posedge pclk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h014, 32'h10);
    rd(12'h018, 32'h0);
    chk("pslverr", h.rerr, 32'h1);
    h.xfer(1'b1, 12'h004, en);
    rd(12'h010, en);
    h.run(32'h1);
    chk("slots", q.size(), 12);
    foreach (q[i]) begin
      g = ~(6'h1 << (i % 6) | 6'h1 << ((i + 1) % 6) | 6'h1 << ((i + 5) % 6));
      chk("slot", q[i], en & {3{g}});
    end
    q.delete();
    h.xfer(1'b1, 12'h000, 32'h1);
    h.run(32'h1);
    chk("frozen", q.size(), 0);
    h.xfer(1'b1, 12'h008, 32'h4);
    rd(12'h010, 32'h0);
    h.run(32'h1);
    rd(12'h010, 32'h0);
    rd(12'h00c, 32'h6);
    rd(12'h004, en);
    h.xfer(1'b1, 12'h008, 32'h8);
    rd(12'h010, en);
    h.measure(3);
    rd(12'h010, en);
    stop_test;
  end
endmodule : test_dmg_gating
`default_nettype wire
